// ===== logic/host_port_pin_control.sv
// Host port pin control with its software register file.
// Overview of operation
// [R1] Disabled port or wide mode turns the byte pins into GPIO.
// [R2] Byte pins float unless driving, and always while output disable is low.
// [R3] Bus holders keep the level last driven while nothing drives.
// [R4] In byte mode holders are off after reset until software turns them on.
// [R5] In byte mode the holder enable bit switches the holders.
// [R6] In wide mode the holders are always active.
// [R7] Register select pair steers each access to one of three registers.
// [R8] Byte order flag marks first or second byte of a halfword.
// [R9] Host holds port select low for the whole access.
// [R10] Two transfer strobes combine to time each transfer.
// [R11] Address strobe latches the address for multiplexed hosts.
// [R12] Port enable strap sampled at reset release; else disabled.
// [R13] Wide strap high selects non-multiplexed mode, no select accesses.
// [R14] Select fields latch at address strobe fall, else strobe fall.
`timescale 1ns/10ps
module host_port_pin_control (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire host_port_pkg::hostPins_t  hostPins,
   input  wire logic [7:0]                hostDataIn,
   output wire logic [7:0]                hostDataOut,
   output wire logic [7:0]                hostDataOe,
   output wire logic                      holderActive,
   output logic      [7:0]                holderLevel,
   input  wire logic                      outputDisableN,
   input  wire logic                      portEnableStrap,
   input  wire logic                      wideModeStrap,
   input  wire logic [5:0]                awaddr,
   input  wire logic                      awvalid,
   output wire logic                      awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output wire logic                      wready,
   output logic      [1:0]                bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic [5:0]                araddr,
   input  wire logic                      arvalid,
   output wire logic                      arready,
   output logic      [31:0]               rdata,
   output logic      [1:0]                rresp,
   output logic                           rvalid,
   input  wire logic                      rready
);
   // ==========================================================
   // Straps and mode
   // ==========================================================
   logic portEnabled;
   logic wideMode;

   // The straps follow the pins while reset is held, so the value
   // standing at the release is the one kept.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         portEnabled <= portEnableStrap; // see [R12]
         wideMode    <= wideModeStrap;   // see [R13]
      end
   end

   wire muxMode  = portEnabled & ~wideMode; // see [R13]
   wire gpioMode = ~muxMode;                // see [R1]

   // ==========================================================
   // Software registers
   // ==========================================================
   logic [15:0] ctrl;
   logic [7:0]  gpioDir;
   logic [7:0]  gpioOut;
   logic [15:0] toHost;
   logic        hostWrote;
   wire  useAddrStb = ctrl[host_port_pkg::CTRL_ADDRSTB];

   // ==========================================================
   // Strobes
   // ==========================================================
   // Exactly one data strobe low with the port selected marks a transfer.
   wire strobeLvlN = hostPins.portSelectN |
                     ~(hostPins.transferStrobeAN ^
                       hostPins.transferStrobeBN); // see [R9] see [R10]
   logic strobeFall;
   logic strobeRise;
   logic addrFall;

   strobe_edge uStrobeEdge (
      .clk    (clk),
      .rst_n  (rst_n),
      .levelN (strobeLvlN),
      .fall   (strobeFall),
      .rise   (strobeRise)
   );

   strobe_edge uAddrEdge (
      .clk    (clk),
      .rst_n  (rst_n),
      .levelN (hostPins.addrStrobeN),
      .fall   (addrFall),
      .rise   ()
   );

   // ==========================================================
   // Access latch
   // ==========================================================
   logic [1:0] latSel;
   logic       latSecond;
   logic       latRead;
   logic [7:0] latBus;
   wire  [1:0] pinSel = {hostPins.registerSelectHi,
                         hostPins.registerSelectLo};
   wire  addrLatch = muxMode & useAddrStb & addrFall;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latSel    <= host_port_pkg::SEL_CTRL;
         latSecond <= 1'b0;
         latRead   <= 1'b0;
         latBus    <= host_port_pkg::GPIO_RST;
      end else if (addrLatch) begin
         latSel    <= pinSel;                 // see [R11] see [R14]
         latSecond <= hostPins.byteOrderFlag;
         latRead   <= hostPins.readNotWrite;
         latBus    <= hostDataIn;
      end
   end

   // Fields in force for a transfer that starts this cycle.
   wire [1:0] effSel    = useAddrStb ? latSel : pinSel; // see [R14]
   wire       effSecond = useAddrStb ? latSecond
                                     : hostPins.byteOrderFlag;
   wire       effRead   = useAddrStb ? latRead : hostPins.readNotWrite;

   // ==========================================================
   // Transfer state
   // ==========================================================
   host_port_pkg::xferState_t state;
   host_port_pkg::xferState_t next_state;
   logic [1:0] xSel;
   logic       xSecond;
   logic       xRead;
   logic [7:0] driveByte;
   logic [15:0] hostCtrlWord;
   logic [15:0] hostAddr;
   logic [15:0] hostDataWord;

   wire startXfer = muxMode & strobeFall;
   wire inXfer    = (state == host_port_pkg::ST_XFER);
   wire endXfer   = inXfer & strobeRise;

   always_comb begin
      next_state = state;
      unique case (state)
         host_port_pkg::ST_IDLE: begin
            if (startXfer) begin
               next_state = host_port_pkg::ST_XFER;
            end
         end
         host_port_pkg::ST_XFER: begin
            if (strobeRise || !muxMode) begin
               next_state = host_port_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   // Word offered to a host read, picked by the register select code.
   wire [15:0] readWord =
      (effSel == host_port_pkg::SEL_CTRL) ? hostCtrlWord :
      (effSel == host_port_pkg::SEL_ADDR) ? hostAddr : toHost; // see [R7]
   // First byte is the high byte, second the low byte.
   wire [7:0] readByte = effSecond ? readWord[7:0]
                                   : readWord[15:8]; // see [R8]

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= host_port_pkg::ST_IDLE;
         xSel      <= host_port_pkg::SEL_CTRL;
         xSecond   <= 1'b0;
         xRead     <= 1'b0;
         driveByte <= host_port_pkg::GPIO_RST;
      end else begin
         state <= next_state;
         if (startXfer) begin
            xSel      <= effSel;
            xSecond   <= effSecond;
            xRead     <= effRead;
            driveByte <= readByte;
         end
      end
   end

   // Host writes land at the end of the strobe; data accesses with
   // increment advance the address after the second byte.
   wire hostWr  = endXfer & ~xRead;
   wire isData  = (xSel == host_port_pkg::SEL_DATA) |
                  (xSel == host_port_pkg::SEL_DATA_INC);
   wire addrInc = endXfer & xSecond &
                  (xSel == host_port_pkg::SEL_DATA_INC);
   wire wroteSet = hostWr & xSecond & isData;

   function automatic logic [15:0] putByte(input logic [15:0] w,
                                           input logic        second,
                                           input logic [7:0]  b);
      putByte = second ? {w[15:8], b} : {b, w[7:0]};
   endfunction : putByte

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hostCtrlWord <= host_port_pkg::WORD_RST;
         hostAddr     <= host_port_pkg::WORD_RST;
         hostDataWord <= host_port_pkg::WORD_RST;
      end else begin
         if (hostWr && xSel == host_port_pkg::SEL_CTRL) begin
            hostCtrlWord <= putByte(hostCtrlWord, xSecond, hostDataIn);
         end
         if (hostWr && xSel == host_port_pkg::SEL_ADDR) begin
            hostAddr <= putByte(hostAddr, xSecond, hostDataIn); // see [R7]
         end else if (addrInc) begin
            hostAddr <= hostAddr + 16'h0001;
         end
         if (hostWr && isData) begin
            hostDataWord <= putByte(hostDataWord, xSecond,
                                    hostDataIn); // see [R8]
         end
      end
   end

   // ==========================================================
   // Pin drive and holders
   // ==========================================================
   wire       hostDriving = inXfer & xRead & muxMode;
   wire [7:0] pinOeRaw    = gpioMode ? gpioDir
                                     : {8{hostDriving}}; // see [R1]
   assign hostDataOe  = outputDisableN ? pinOeRaw : 8'h00; // see [R2]
   assign hostDataOut = gpioMode ? gpioOut : driveByte;
   assign holderActive = wideMode | ctrl[host_port_pkg::CTRL_HOLDER];
   // see [R5] see [R6]

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         holderLevel <= host_port_pkg::GPIO_RST;
      end else begin
         holderLevel <= (hostDataOe & hostDataOut) |
                        (~hostDataOe & holderLevel); // see [R3]
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   logic        awHeld;
   logic        wHeld;
   logic [5:0]  awAddrReg;
   logic [31:0] wDataReg;
   logic [3:0]  wStrbReg;

   assign awready = ~awHeld & ~bvalid;
   assign wready  = ~wHeld & ~bvalid;
   assign arready = ~rvalid;

   wire doWrite = awHeld & wHeld & ~bvalid;
   wire wrCtrl  = doWrite & (awAddrReg == host_port_pkg::OFS_CTRL);
   wire wrDir   = doWrite & (awAddrReg == host_port_pkg::OFS_GPIO_DIR);
   wire wrOut   = doWrite & (awAddrReg == host_port_pkg::OFS_GPIO_OUT);
   wire wrStat  = doWrite & (awAddrReg == host_port_pkg::OFS_STATUS);
   wire wrToH   = doWrite & (awAddrReg == host_port_pkg::OFS_TO_HOST);
   wire wrMapped = (awAddrReg <= host_port_pkg::OFS_TO_HOST) &
                   (awAddrReg[1:0] == 2'h0);
   wire wroteClr = wrStat & wStrbReg[0] &
                   wDataReg[host_port_pkg::STAT_WROTE];

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld    <= 1'b0;
         wHeld     <= 1'b0;
         awAddrReg <= 6'h00;
         wDataReg  <= 32'h00000000;
         wStrbReg  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= host_port_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld    <= 1'b1;
            awAddrReg <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld    <= 1'b1;
            wDataReg <= wdata;
            wStrbReg <= wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= wrMapped ? host_port_pkg::RESP_OKAY
                               : host_port_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl      <= host_port_pkg::CTRL_RST; // see [R4]
         gpioDir   <= host_port_pkg::GPIO_RST;
         gpioOut   <= host_port_pkg::GPIO_RST;
         toHost    <= host_port_pkg::WORD_RST;
         hostWrote <= 1'b0;
      end else begin
         if (wrCtrl) begin
            ctrl <= merge16(ctrl, wDataReg, wStrbReg); // see [R5]
         end
         if (wrDir && wStrbReg[0]) begin
            gpioDir <= wDataReg[7:0];
         end
         if (wrOut && wStrbReg[0]) begin
            gpioOut <= wDataReg[7:0];
         end
         if (wrToH) begin
            toHost <= merge16(toHost, wDataReg, wStrbReg);
         end
         // A host write in the clearing cycle keeps the flag set.
         hostWrote <= wroteSet | (hostWrote & ~wroteClr);
      end
   end

   wire [15:0] statusWord = {latBus, latSecond, latSel, inXfer,
                             holderActive, wideMode, portEnabled,
                             hostWrote};
   wire [15:0] rdWord =
      (araddr == host_port_pkg::OFS_CTRL)     ? ctrl :
      (araddr == host_port_pkg::OFS_GPIO_DIR) ? {8'h00, gpioDir} :
      (araddr == host_port_pkg::OFS_GPIO_OUT) ? {8'h00, gpioOut} :
      (araddr == host_port_pkg::OFS_GPIO_IN)  ? {8'h00, hostDataIn} :
      (araddr == host_port_pkg::OFS_STATUS)   ? statusWord :
      (araddr == host_port_pkg::OFS_HOST_CTL) ? hostCtrlWord :
      (araddr == host_port_pkg::OFS_HOST_ADR) ? hostAddr :
      (araddr == host_port_pkg::OFS_HOST_DAT) ? hostDataWord :
      (araddr == host_port_pkg::OFS_TO_HOST)  ? toHost : 16'h0000;
   wire rdMapped = (araddr <= host_port_pkg::OFS_TO_HOST) &
                   (araddr[1:0] == 2'h0);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= host_port_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= {16'h0000, rdWord};
         rresp  <= rdMapped ? host_port_pkg::RESP_OKAY
                            : host_port_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   sequence sReadStart;
      startXfer && effRead;
   endsequence

   sequence sAddrWrite;
      endXfer && !xRead && xSel == host_port_pkg::SEL_ADDR && xSecond;
   endsequence

   a_off_float: assert property ( // see [R2]
      @(posedge clk) disable iff (!rst_n)
      !outputDisableN |-> hostDataOe == 8'h00)
      else $error("Byte pins driven while output disable is low.");

   a_gpio_pins: assert property ( // see [R1]
      @(posedge clk) disable iff (!rst_n)
      gpioMode && outputDisableN |-> hostDataOe == gpioDir)
      else $error("GPIO direction not applied to byte pins.");

   a_read_drive: assert property ( // see [R10]
      @(posedge clk) disable iff (!rst_n)
      sReadStart |=> (hostDataOut == $past(readByte))
                     throughout (inXfer [*1]))
      else $error("Host read does not drive the selected byte.");

   a_holder_level: assert property ( // see [R3]
      @(posedge clk) disable iff (!rst_n)
      hostDataOe[0] |=> holderLevel[0] == $past(hostDataOut[0]))
      else $error("Holder level does not follow last driven bit.");

   a_holder_reset: assert property ( // see [R4]
      @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) && !wideMode |-> !holderActive)
      else $error("Holders active straight after reset.");

   a_holder_bit: assert property ( // see [R5]
      @(posedge clk) disable iff (!rst_n)
      !wideMode |-> holderActive == ctrl[host_port_pkg::CTRL_HOLDER])
      else $error("Holder enable bit ignored in byte mode.");

   a_holder_wide: assert property ( // see [R6]
      @(posedge clk) disable iff (!rst_n)
      wideMode |-> holderActive)
      else $error("Holders off in wide mode.");

   a_addr_write: assert property ( // see [R7] see [R8]
      @(posedge clk) disable iff (!rst_n)
      sAddrWrite |=> hostAddr[7:0] == $past(hostDataIn))
      else $error("Second address byte not stored in low half.");

   a_addr_latch: assert property ( // see [R11] see [R14]
      @(posedge clk) disable iff (!rst_n)
      addrLatch |=> latSel == $past(pinSel) && latBus == $past(hostDataIn))
      else $error("Address strobe did not latch select and address.");

   a_strap_kept: assert property ( // see [R12]
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> $stable(portEnabled) && $stable(wideMode))
      else $error("Strap value changed outside reset.");

   a_wide_quiet: assert property ( // see [R13]
      @(posedge clk) disable iff (!rst_n)
      wideMode |-> !inXfer ##1 !inXfer)
      else $error("Select access started in wide mode.");

endmodule : host_port_pin_control

// ===== logic/host_port_pkg.sv
// Constants, register map and types for the host port pin control block.
package host_port_pkg;

   // ==========================================================
   // Register bus
   // ==========================================================
   localparam int          ADDR_W       = 6;
   localparam logic [5:0]  OFS_CTRL     = 6'h00;
   localparam logic [5:0]  OFS_GPIO_DIR = 6'h04;
   localparam logic [5:0]  OFS_GPIO_OUT = 6'h08;
   localparam logic [5:0]  OFS_GPIO_IN  = 6'h0c;
   localparam logic [5:0]  OFS_STATUS   = 6'h10;
   localparam logic [5:0]  OFS_HOST_CTL = 6'h14;
   localparam logic [5:0]  OFS_HOST_ADR = 6'h18;
   localparam logic [5:0]  OFS_HOST_DAT = 6'h1c;
   localparam logic [5:0]  OFS_TO_HOST  = 6'h20;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int          CTRL_HOLDER  = 0;
   localparam int          CTRL_ADDRSTB = 1;
   localparam int          STAT_WROTE   = 0;
   localparam logic [15:0] CTRL_RST     = 16'h0000;
   localparam logic [7:0]  GPIO_RST     = 8'h00;
   localparam logic [15:0] WORD_RST     = 16'h0000;

   // ==========================================================
   // Host register select codes
   // ==========================================================
   localparam logic [1:0]  SEL_CTRL     = 2'h0;
   localparam logic [1:0]  SEL_DATA_INC = 2'h1;
   localparam logic [1:0]  SEL_ADDR     = 2'h2;
   localparam logic [1:0]  SEL_DATA     = 2'h3;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic portSelectN;
      logic transferStrobeAN;
      logic transferStrobeBN;
      logic addrStrobeN;
      logic readNotWrite;
      logic registerSelectHi;
      logic registerSelectLo;
      logic byteOrderFlag;
   } hostPins_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_XFER = 2'h2
   } xferState_t;

endpackage : host_port_pkg

// ===== logic/strobe_edge.sv
// Edge detector for an active-low strobe level.
`timescale 1ns/10ps
module strobe_edge (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic levelN,
   output wire logic fall,
   output wire logic rise
);
   logic prev;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev <= 1'b1;
      end else begin
         prev <= levelN;
      end
   end

   assign fall = prev & ~levelN;
   assign rise = ~prev & levelN;

endmodule : strobe_edge

// ===== dv/host_model.sv
// Host processor model that drives the port strobes and the byte pins.
`timescale 1ns/10ps
module host_model (
   input  wire logic                     clk,
   output host_port_pkg::hostPins_t      pins,
   output logic      [7:0]               dataIn,
   input  wire logic [7:0]               devOut,
   input  wire logic [7:0]               devOe,
   input  wire logic                     holdOn,
   input  wire logic [7:0]               holdLvl
);
   logic [7:0] hostByte;
   logic       hostOe;
   logic [7:0] drift;

   // ==========================================================
   // Wire level
   // ==========================================================
   // A bit nobody drives or holds shows a pattern that changes every cycle.
   initial begin
      pins = 8'hf0;
      hostByte = 8'h00;
      hostOe = 1'b0;
      drift = 8'h69;
   end
   always @(posedge clk) begin
      drift <= ~drift;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         dataIn[i] = devOe[i] ? devOut[i] : hostOe ? hostByte[i]
                   : holdOn ? holdLvl[i] : drift[i];
      end
   end

   // ==========================================================
   // One byte transfer
   // ==========================================================
   task automatic xfer(input logic rd, input logic [1:0] sel,
                       input logic second, input logic [7:0] wb,
                       output logic [7:0] got, output logic [7:0] oe);
      @(posedge clk);
      pins <= {1'b0, 1'b0, 1'b1, 1'b1,
               rd, sel, second};
      hostByte <= wb;
      hostOe <= !rd;
      repeat (3) @(posedge clk);
      got = dataIn;
      oe = devOe;
      pins <= 8'hf0;
      // Write data stays on the pins one edge past the strobe release.
      @(posedge clk);
      hostOe <= 1'b0;
      @(posedge clk);
   endtask : xfer

   // Write with the fields and address byte given under the address strobe;
   // the select pins show other values while the data strobe is low.
   task automatic latched(input logic [1:0] sel, input logic second,
                          input logic [7:0] ab, input logic [7:0] wb);
      @(posedge clk);
      pins <= {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, sel, second};
      hostByte <= ab;
      hostOe <= 1'b1;
      @(posedge clk);
      pins <= {1'b0, 1'b1, 1'b0, 1'b1,
               1'b0, ~sel, ~second};
      hostByte <= wb;
      repeat (3) @(posedge clk);
      pins <= 8'hf0;
      @(posedge clk);
      hostOe <= 1'b0;
      @(posedge clk);
   endtask : latched
endmodule : host_model

// ===== dv/host_port_pin_control_tb.sv
// Self-checking testbench for the host port pin control block.
`timescale 1ns/10ps
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin badCount++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module host_port_pin_control_tb;
   logic clk = 0, rst_n = 0, outputDisableN = 1, pe = 1, wm = 0;
   logic awvalid = 0, wvalid = 0, arvalid = 0;
   logic [5:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [7:0] hostDataIn, hostDataOut, hostDataOe, holderLevel, got, oe;
   logic bvalid, rvalid, awready, wready, arready, holderActive;
   host_port_pkg::hostPins_t hostPins;
   int badCount = 0, cmpCount = 0;

   always #50 clk = ~clk;

   host_port_pin_control host_port_pin_control_inst (.clk(clk),
      .rst_n(rst_n), .hostPins(hostPins), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
      .holderActive(holderActive), .holderLevel(holderLevel),
      .outputDisableN(outputDisableN), .portEnableStrap(pe),
      .wideModeStrap(wm), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1));
   host_model host_model_inst (.clk(clk), .pins(hostPins),
      .dataIn(hostDataIn), .devOut(hostDataOut), .devOe(hostDataOe),
      .holdOn(holderActive), .holdLvl(holderLevel));

   // ==========================================================
   // Bus and run control
   // ==========================================================
   task automatic reportAndStop();
      $display("compares %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : reportAndStop
   task automatic axiWr(input logic [5:0] a, input logic [31:0] v);
      int n;
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      if (n == 50) begin badCount++; reportAndStop(); end
   endtask : axiWr
   task automatic axiRd(input logic [5:0] a);
      int n;
      araddr <= a; arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      r = rresp; d = rdata;
      if (n == 50) begin badCount++; reportAndStop(); end
   endtask : axiRd
   task automatic doReset(input logic enable, input logic wide);
      rst_n <= 1'b0; pe <= enable; wm <= wide;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : doReset
   task automatic hostWord(input logic [1:0] sel, input logic [15:0] w);
      host_model_inst.xfer(1'b0, sel, 1'b0, w[15:8], got, oe);
      host_model_inst.xfer(1'b0, sel, 1'b1, w[7:0], got, oe);
   endtask : hostWord

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic hostWrites();
      hostWord(host_port_pkg::SEL_ADDR, 16'h1234);
      hostWord(host_port_pkg::SEL_DATA, 16'hbeef);
      axiRd(host_port_pkg::OFS_HOST_DAT);
      `CHK(d, 32'h0000beef)
      axiRd(host_port_pkg::OFS_STATUS);
      `CHK(d[0], 1'b1)
      hostWord(host_port_pkg::SEL_DATA_INC, 16'hcafe);
      axiRd(host_port_pkg::OFS_HOST_DAT);
      `CHK(d, 32'h0000cafe)
      axiRd(host_port_pkg::OFS_HOST_ADR);
      `CHK(d, 32'h00001235)
   endtask : hostWrites
   task automatic hostReads();
      axiWr(host_port_pkg::OFS_TO_HOST, 32'h0000abcd);
      axiWr(host_port_pkg::OFS_CTRL, 32'h1);
      `CHK(holderActive, 1'b1)
      host_model_inst.xfer(1'b1, host_port_pkg::SEL_DATA, 1'b0, 8'h00,
                           got, oe);
      `CHK(oe, 8'hff)
      `CHK(got, 8'hab)
      host_model_inst.xfer(1'b1, host_port_pkg::SEL_DATA, 1'b1, 8'h00,
                           got, oe);
      `CHK(got, 8'hcd)
      `CHK(hostDataOe, 8'h00)
      `CHK(hostDataIn, 8'hcd)
      `CHK(holderLevel, 8'hcd)
      outputDisableN <= 1'b0;
      host_model_inst.xfer(1'b1, host_port_pkg::SEL_DATA, 1'b0, 8'h00,
                           got, oe);
      `CHK(oe, 8'h00)
      outputDisableN <= 1'b1;
      axiWr(host_port_pkg::OFS_CTRL, 32'h0);
      `CHK(holderActive, 1'b0)
      axiRd(6'h24);
      `CHK(r, host_port_pkg::RESP_SLVERR)
      axiWr(6'h24, 32'h1);
      `CHK(r, host_port_pkg::RESP_SLVERR)
   endtask : hostReads
   task automatic hostLatched();
      axiWr(host_port_pkg::OFS_CTRL, 32'h2);
      host_model_inst.latched(host_port_pkg::SEL_CTRL, 1'b0, 8'h3c, 8'h5c);
      axiRd(host_port_pkg::OFS_HOST_CTL);
      `CHK(d, 32'h00005c00)
      axiRd(host_port_pkg::OFS_HOST_DAT);
      `CHK(d, 32'h0000cafe)
      axiRd(host_port_pkg::OFS_STATUS);
      `CHK(d[15:5], 11'h1e0)
      axiWr(host_port_pkg::OFS_CTRL, 32'h0);
   endtask : hostLatched
   task automatic gpioMode(input logic enable, input logic wide);
      doReset(enable, wide);
      `CHK(holderActive, wide)
      axiWr(host_port_pkg::OFS_GPIO_DIR, 32'hff);
      axiWr(host_port_pkg::OFS_GPIO_OUT, 32'h5a);
      `CHK(hostDataOe, 8'hff)
      `CHK(hostDataOut, 8'h5a)
      pe <= 1'b1;
      hostWord(host_port_pkg::SEL_ADDR, 16'h7777);
      axiRd(host_port_pkg::OFS_HOST_ADR);
      `CHK(d, 32'h0)
   endtask : gpioMode

   initial begin
      doReset(1'b1, 1'b0);
      `CHK(holderActive, 1'b0)
      `CHK(hostDataOe, 8'h00)
      hostWrites();
      hostReads();
      hostLatched();
      gpioMode(1'b1, 1'b1);
      gpioMode(1'b0, 1'b0);
      reportAndStop();
   end
endmodule : host_port_pin_control_tb
